// ### ncb_pkg.sv
// Shared constants and types for the negate, compare and bit-op slice
package ncb_pkg;

  // ==========================================================
  // Widths and reset values
  localparam int DATA_W = 8;
  localparam int IDX_W = 3;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;

  // ==========================================================
  // Flag positions in the flag vector {signed_wrap, half, carry, zero}
  localparam int FLAG_Z = 0;
  localparam int FLAG_C = 1;
  localparam int FLAG_AC = 2;
  localparam int FLAG_OV = 3;
  localparam int NIB_W = 4;

  // ==========================================================
  // Operation codes
  typedef enum logic [2:0] {
    NCB_OP_NEG_MEM = 3'b000,
    NCB_OP_CMP_AM = 3'b001,
    NCB_OP_CMP_MA = 3'b010,
    NCB_OP_IO_CLR = 3'b011,
    NCB_OP_IO_SET = 3'b100,
    NCB_OP_SWAPC = 3'b101,
    NCB_OP_MEM_CLR = 3'b110,
    NCB_OP_MEM_SET = 3'b111
  } ncb_op_t;

endpackage

// ### ncb_sub.sv
// Byte subtractor producing the four arithmetic flags
module ncb_sub (
  // Operands
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  // Result and flags
  output logic [7:0] diff,
  output logic zero_out,
  output logic borrow_out,
  output logic half_borrow_out,
  output logic wrap_out
);

  // ==========================================================
  // Arithmetic
  wire logic [8:0] full_diff;
  wire logic [4:0] low_diff;

  assign full_diff = {1'b0, minuend} - {1'b0, subtrahend};
  assign low_diff = {1'b0, minuend[ncb_pkg::NIB_W-1:0]}
                  - {1'b0, subtrahend[ncb_pkg::NIB_W-1:0]};
  assign diff = full_diff[7:0];
  assign zero_out = (full_diff[7:0] == 8'h00);
  // Borrow out of bit 7 means minuend below subtrahend unsigned
  assign borrow_out = full_diff[8];
  assign half_borrow_out = low_diff[4];
  // Signs differ and result sign follows the subtrahend
  assign wrap_out = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ full_diff[7]);

endmodule // ncb_sub

// ### ncb_core.sv
// Execution slice: memory negate, compares and single-bit operations
module ncb_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Decoded instruction
  input wire logic op_valid,
  input wire ncb_pkg::ncb_op_t op_code,
  input wire logic [2:0] bit_idx,
  // Operands
  input wire logic [7:0] working_register,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] io_dir_out,
  input wire logic [7:0] port_pins,
  // Memory write
  output logic mem_we,
  output logic [7:0] mem_wdata,
  // I/O register write
  output logic io_we,
  output logic [7:0] io_wdata,
  // Status flags
  output logic zero_flag,
  output logic carry_flag,
  output logic half_carry_flag,
  output logic signed_wrap_flag,
  output logic op_done
);

  // ==========================================================
  // Helpers
  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'h01 << idx;
  endfunction

  // Force one bit to a level; shared by the port and memory bit ops
  function automatic logic [7:0] bit_force(input logic [7:0] value,
                                           input logic [2:0] idx,
                                           input logic level);
    bit_force = level ? (value | bit_mask(idx)) : (value & ~bit_mask(idx));
  endfunction

  // ==========================================================
  // Pin synchroniser
  logic [7:0] pin_meta_reg;
  logic [7:0] pin_sync_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_reg <= ncb_pkg::DATA_RST;
      pin_sync_reg <= ncb_pkg::DATA_RST;
    end else begin
      pin_meta_reg <= port_pins;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ==========================================================
  // Decode
  wire logic is_neg;
  wire logic is_cmp_am;
  wire logic is_cmp_ma;
  wire logic is_io_clr;
  wire logic is_io_set;
  wire logic is_swapc;
  wire logic is_mem_clr;
  wire logic is_mem_set;

  assign is_neg = op_valid && (op_code == ncb_pkg::NCB_OP_NEG_MEM);
  assign is_cmp_am = op_valid && (op_code == ncb_pkg::NCB_OP_CMP_AM);
  assign is_cmp_ma = op_valid && (op_code == ncb_pkg::NCB_OP_CMP_MA);
  assign is_io_clr = op_valid && (op_code == ncb_pkg::NCB_OP_IO_CLR);
  assign is_io_set = op_valid && (op_code == ncb_pkg::NCB_OP_IO_SET);
  assign is_swapc = op_valid && (op_code == ncb_pkg::NCB_OP_SWAPC);
  assign is_mem_clr = op_valid && (op_code == ncb_pkg::NCB_OP_MEM_CLR);
  assign is_mem_set = op_valid && (op_code == ncb_pkg::NCB_OP_MEM_SET);

  // ==========================================================
  // Shared subtractor
  wire logic [7:0] sub_a;
  wire logic [7:0] sub_b;
  wire logic [7:0] sub_diff;
  wire logic sub_z;
  wire logic sub_c;
  wire logic sub_ac;
  wire logic sub_ov;

  // Negate is 0 - mem; one subtractor serves all three arithmetic ops
  assign sub_a = is_neg ? 8'h00 :
                 is_cmp_ma ? mem_rdata : working_register;
  assign sub_b = (is_neg || is_cmp_am) ? mem_rdata : working_register;

  ncb_sub u_sub (
    .minuend(sub_a),
    .subtrahend(sub_b),
    .diff(sub_diff),
    .zero_out(sub_z),
    .borrow_out(sub_c),
    .half_borrow_out(sub_ac),
    .wrap_out(sub_ov)
  );

  // ==========================================================
  // Bit operations
  wire logic [7:0] mask;
  wire logic io_bit;
  wire logic bit_is_out;
  wire logic swap_carry;

  assign mask = bit_mask(bit_idx);
  assign io_bit = |(io_rdata & mask);
  assign bit_is_out = |(io_dir_out & mask);
  // Input bits take the pin level, not the stale port latch
  assign swap_carry = bit_is_out ? io_bit
                                 : |(pin_sync_reg & mask);

  // ==========================================================
  // Next values
  logic mem_we_next;
  logic [7:0] mem_wdata_next;
  logic io_we_next;
  logic [7:0] io_wdata_next;
  logic [3:0] flags_reg;
  logic [3:0] flags_next;
  wire logic [7:0] io_cleared;
  wire logic [7:0] io_raised;
  wire logic [7:0] io_swapped;
  wire logic [7:0] mem_cleared;
  wire logic [7:0] mem_raised;

  assign io_cleared = bit_force(io_rdata, bit_idx, 1'b0);
  assign io_raised = bit_force(io_rdata, bit_idx, 1'b1);
  // Port bit takes the carry held before this swap
  assign io_swapped = bit_force(io_rdata, bit_idx,
                                flags_reg[ncb_pkg::FLAG_C]);
  assign mem_cleared = bit_force(mem_rdata, bit_idx, 1'b0);
  assign mem_raised = bit_force(mem_rdata, bit_idx, 1'b1);

  always_comb begin
    mem_we_next = 1'b0;
    mem_wdata_next = mem_rdata;
    io_we_next = 1'b0;
    io_wdata_next = io_rdata;
    flags_next = flags_reg;
    if (is_neg) begin
      mem_we_next = 1'b1;
      mem_wdata_next = sub_diff;
      flags_next[ncb_pkg::FLAG_Z] = sub_z;
    end
    if (is_cmp_am || is_cmp_ma) begin
      flags_next[ncb_pkg::FLAG_Z] = sub_z;
      flags_next[ncb_pkg::FLAG_C] = sub_c;
      flags_next[ncb_pkg::FLAG_AC] = sub_ac;
      flags_next[ncb_pkg::FLAG_OV] = sub_ov;
    end
    if (is_io_clr) begin
      io_we_next = 1'b1;
      io_wdata_next = io_cleared;
    end
    if (is_io_set) begin
      io_we_next = 1'b1;
      io_wdata_next = io_raised;
    end
    if (is_swapc) begin
      flags_next[ncb_pkg::FLAG_C] = swap_carry;
      if (bit_is_out) begin
        io_we_next = 1'b1;
        io_wdata_next = io_swapped;
      end
    end
    if (is_mem_clr) begin
      mem_we_next = 1'b1;
      mem_wdata_next = mem_cleared;
    end
    if (is_mem_set) begin
      mem_we_next = 1'b1;
      mem_wdata_next = mem_raised;
    end
  end

  // ==========================================================
  // Registers
  logic mem_we_reg;
  logic [7:0] mem_wdata_reg;
  logic io_we_reg;
  logic [7:0] io_wdata_reg;
  logic done_reg;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= ncb_pkg::DATA_RST;
      io_we_reg <= 1'b0;
      io_wdata_reg <= ncb_pkg::DATA_RST;
      flags_reg <= {4{ncb_pkg::FLAG_RST}};
      done_reg <= 1'b0;
    end else begin
      mem_we_reg <= mem_we_next;
      mem_wdata_reg <= mem_wdata_next;
      io_we_reg <= io_we_next;
      io_wdata_reg <= io_wdata_next;
      flags_reg <= flags_next;
      done_reg <= op_valid;
    end
  end

  assign mem_we = mem_we_reg;
  assign mem_wdata = mem_wdata_reg;
  assign io_we = io_we_reg;
  assign io_wdata = io_wdata_reg;
  assign zero_flag = flags_reg[ncb_pkg::FLAG_Z];
  assign carry_flag = flags_reg[ncb_pkg::FLAG_C];
  assign half_carry_flag = flags_reg[ncb_pkg::FLAG_AC];
  assign signed_wrap_flag = flags_reg[ncb_pkg::FLAG_OV];
  assign op_done = done_reg;

endmodule // ncb_core

// ### ncb_far.sv
// Behavioural memory byte and I/O latch facing the slice
module ncb_far (
  // Clock and bench preload
  input wire logic ref_clk,
  input wire logic ld,
  input wire logic [7:0] ld_mem,
  input wire logic [7:0] ld_io,
  // Writes from the slice
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  // Operands to the slice
  output logic [7:0] mem_rdata = 8'h00,
  output logic [7:0] io_rdata = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  always @(posedge ref_clk) begin
    if (ld) begin
      mem_rdata <= ld_mem;
      io_rdata <= ld_io;
    end else begin
      if (mem_we) mem_rdata <= mem_wdata;
      if (io_we) io_rdata <= io_wdata;
    end
  end
endmodule // ncb_far

// ### ncb_checker.sv
// Port-level properties of the execution slice
module ncb_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic op_valid,
  input wire ncb_pkg::ncb_op_t op_code,
  input wire logic [2:0] bit_idx,
  input wire logic [7:0] working_register,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] io_rdata,
  input wire logic [7:0] io_dir_out,
  input wire logic [7:0] port_pins,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic io_we,
  input wire logic [7:0] io_wdata,
  input wire logic zero_flag,
  input wire logic carry_flag,
  input wire logic half_carry_flag,
  input wire logic signed_wrap_flag,
  input wire logic op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] k, m, ng, ms, mc, is, ic, im;
  // One-hot view of the accepted operation
  assign k = op_valid ? 8'h01 << op_code : 8'h00;
  assign m = 8'h01 << bit_idx;
  assign ng = 8'h00 - mem_rdata;
  assign ms = mem_rdata | m;
  assign mc = mem_rdata & ~m;
  assign is = io_rdata | m;
  assign ic = io_rdata & ~m;
  assign im = io_rdata & m;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_neg_result: assert property (k[0] |=> mem_we &&
    mem_wdata == $past(ng) && zero_flag == (mem_wdata == 8'h00))
    else $error("negate result wrong");
  a_neg_keeps: assert property (k[0] |=> $stable(carry_flag)
    && $stable(half_carry_flag) && $stable(signed_wrap_flag))
    else $error("negate touched flags");
  a_cmp_nowrite: assert property (|k[2:1] |=> op_done &&
    !mem_we && !io_we) else $error("compare wrote back");
  a_cmp_equal: assert property (|k[2:1] &&
    working_register == mem_rdata |=> zero_flag && !carry_flag)
    else $error("equal compare flags wrong");
  a_cmp_borrow: assert property (k[1] |=> carry_flag ==
    ($past(working_register) < $past(mem_rdata))) else $error("borrow");
  a_cmp_rev: assert property (k[2] |=> carry_flag ==
    ($past(mem_rdata) < $past(working_register))) else $error("borrow");
  a_io_clear: assert property (k[3] |=> io_we &&
    io_wdata == $past(ic)) else $error("io clear wrong");
  a_io_set: assert property (k[4] |=> io_we && io_wdata == $past(is))
    else $error("io set wrong");
  a_swap_out: assert property (k[5] && |(io_dir_out & m) |=> io_we &&
    io_wdata[$past(bit_idx)] == $past(carry_flag) &&
    carry_flag == |$past(im)) else $error("swap on output wrong");
  a_swap_in: assert property (k[5] && !(|(io_dir_out & m)) |=>
    !io_we && $stable(zero_flag) &&
    carry_flag == |($past(port_pins, 3) & $past(m)))
    else $error("swap on input wrong");
  a_mem_clear: assert property (k[6] |=> mem_we &&
    mem_wdata == $past(mc)) else $error("mem clear wrong");
  a_mem_set: assert property (k[7] |=> mem_we &&
    mem_wdata == $past(ms)) else $error("mem set wrong");
endmodule // ncb_checker
bind ncb_core ncb_checker ncb_checker_inst (.*);

// ### tb_ncb_core.sv
// Self-checking bench for the negate, compare and bit-op slice
module tb_ncb_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rstn, op_valid, ld, mem_we, io_we, op_done;
  logic zero_flag, carry_flag, half_carry_flag, signed_wrap_flag;
  ncb_pkg::ncb_op_t op_code;
  logic [2:0] bit_idx;
  logic [7:0] working_register, mem_rdata, io_rdata, io_dir_out, port_pins;
  logic [7:0] mem_wdata, io_wdata, ld_mem, ld_io;
  int miscompares, n_tests;
  ncb_core ncb_core_inst (.*);
  ncb_far ncb_far_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // ==========================================================
  // One operation; flags expected as {wrap, half, carry, zero}
  task automatic run(input logic [2:0] c, input logic [2:0] b,
      input logic [7:0] w, input logic [7:0] mv, input logic [7:0] iv,
      input logic [1:0] we, input logic [7:0] d, input logic [3:0] f);
    @(posedge ref_clk);
    ld <= 1'b1;
    ld_mem <= mv;
    ld_io <= iv;
    #1;
    // Last op's strobes must have dropped after one cycle
    check({5'h00, op_done, mem_we, io_we}, 8'h00);
    @(posedge ref_clk);
    ld <= 1'b0;
    op_valid <= 1'b1;
    op_code <= ncb_pkg::ncb_op_t'(c);
    bit_idx <= b;
    working_register <= w;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    #1;
    check({6'h00, mem_we, io_we}, {6'h00, we});
    check({7'h00, op_done}, 8'h01);
    if (we[1]) check(mem_wdata, d);
    if (we[0]) check(io_wdata, d);
    check({signed_wrap_flag, half_carry_flag, carry_flag, zero_flag}, f);
    $display("op %0h done", c);
  endtask
  task automatic finish_test;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {rstn, op_valid, ld, bit_idx, working_register} = '0;
    {ld_mem, ld_io, io_dir_out, port_pins} = '0;
    op_code = ncb_pkg::NCB_OP_NEG_MEM;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    run(3'h0, 3'h0, 8'h00, 8'h38, 8'h00, 2'h2, 8'hc8, 4'h0);
    run(3'h1, 3'h0, 8'h38, 8'h42, 8'h00, 2'h0, 8'h00, 4'h2);
    run(3'h1, 3'h0, 8'h70, 8'h81, 8'h00, 2'h0, 8'h00, 4'he);
    run(3'h0, 3'h0, 8'h00, 8'h00, 8'h00, 2'h2, 8'h00, 4'hf);
    run(3'h2, 3'h0, 8'h01, 8'h80, 8'h00, 2'h0, 8'h00, 4'hc);
    run(3'h1, 3'h0, 8'h5a, 8'h5a, 8'h00, 2'h0, 8'h00, 4'h1);
    run(3'h3, 3'h0, 8'h00, 8'h00, 8'hff, 2'h1, 8'hfe, 4'h1);
    run(3'h4, 3'h7, 8'h00, 8'h00, 8'h00, 2'h1, 8'h80, 4'h1);
    run(3'h2, 3'h0, 8'h01, 8'h00, 8'h00, 2'h0, 8'h00, 4'h6);
    @(posedge ref_clk);
    io_dir_out <= 8'h08;
    port_pins <= 8'h20;
    run(3'h5, 3'h3, 8'h00, 8'h00, 8'hf7, 2'h1, 8'hff, 4'h4);
    @(posedge ref_clk);
    io_dir_out <= 8'h00;
    run(3'h5, 3'h5, 8'h00, 8'h00, 8'h00, 2'h0, 8'h00, 4'h6);
    run(3'h6, 3'h2, 8'h00, 8'hff, 8'h00, 2'h2, 8'hfb, 4'h6);
    run(3'h7, 3'h4, 8'h00, 8'h00, 8'h00, 2'h2, 8'h10, 4'h6);
    // Reset in mid-run must clear the held flags
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    run(3'h0, 3'h0, 8'h00, 8'h01, 8'h00, 2'h2, 8'hff, 4'h0);
    finish_test();
  end
  // Bench needs about 50 cycles; cut off well beyond that
  initial begin
    #100000;
    miscompares++;
    finish_test();
  end
endmodule // tb_ncb_core
